// ===== hdl/ovb_pkg.sv
// Notes on behaviour
// - load above level for timer period trips stop
// - action 0 off, 1 decel, 2 coast, 3 hold
// - trip latched until run goes off
// - condition 0 const/decel, 1 const, 2 all
// - modes 1,2 act after timer holds fully
// - mode 3 ignores timer, acts at once
// - release after current, frequency above for timer
// - release current 0 to 200 percent rated
// - release frequency 0..25.0 Hz, timer 0..5.0 s
// - engage after run off, frequency low for timer
// - engage frequency 0..25.0 Hz, timer 0..5.0 s
// - motor 2 selected keeps brake engaged
// - alarm or coast stop engages brake at once
package ovb_pkg;
   localparam int CLK_PERIOD_NS = 5;
   // timer setting resolution is 0.1 s
   localparam int TICK_TIME_MS = 100;
   localparam int TICK_CYCLES_DFLT = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int MEAS_W = 16;
   localparam int SET_W = 8;

   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_OVL_LEVEL = 4'h1;
   localparam logic [3:0] REG_OVL_TIMER = 4'h2;
   localparam logic [3:0] REG_REL_CUR = 4'h3;
   localparam logic [3:0] REG_REL_FREQ = 4'h4;
   localparam logic [3:0] REG_REL_TIMER = 4'h5;
   localparam logic [3:0] REG_ENG_FREQ = 4'h6;
   localparam logic [3:0] REG_ENG_TIMER = 4'h7;
   localparam logic [3:0] REG_STATUS = 4'h8;

   localparam int CTRL_ACT_LSB = 0;
   localparam int CTRL_COND_LSB = 2;
   localparam int STAT_BRAKE_BIT = 0;
   localparam int STAT_LATCH_BIT = 1;
   localparam int STAT_DECEL_BIT = 2;
   localparam int STAT_COAST_BIT = 3;
   localparam int STAT_HOLD_BIT = 4;
   localparam int STAT_W = 5;

   localparam logic [SET_W-1:0] REL_CUR_MAX = 8'hC8;
   localparam logic [SET_W-1:0] FREQ_MAX = 8'hFA;
   localparam logic [SET_W-1:0] HOLD_MAX = 8'h32;

   localparam logic [1:0] RST_ACT = 2'h0;
   localparam logic [1:0] RST_COND = 2'h0;
   localparam logic [MEAS_W-1:0] RST_OVL_LEVEL = 16'h0064;
   localparam logic [MEAS_W-1:0] RST_OVL_TIMER = 16'h0000;
   localparam logic [SET_W-1:0] RST_SET = 8'h00;

   typedef enum logic [1:0] {OP_ACCEL, OP_CONST, OP_DECEL} ovb_op_e;
   typedef enum logic [1:0] {ACT_OFF, ACT_DECEL, ACT_COAST, ACT_HOLD} ovb_act_e;
   typedef enum logic [1:0] {COND_CONST_DECEL, COND_CONST, COND_ALL} ovb_cond_e;
   typedef enum logic {BRK_ENGAGED, BRK_RELEASED} ovb_brk_e;
endpackage

// ===== hdl/ovb_cfg_if.sv
`timescale 1ns/1ps
interface ovb_cfg_if;
   import ovb_pkg::*;
   logic [1:0] act;
   logic [1:0] cond;
   logic [MEAS_W-1:0] ovl_level;
   logic [MEAS_W-1:0] ovl_timer;
   logic [SET_W-1:0] rel_cur;
   logic [SET_W-1:0] rel_freq;
   logic [SET_W-1:0] rel_timer;
   logic [SET_W-1:0] eng_freq;
   logic [SET_W-1:0] eng_timer;
   logic [STAT_W-1:0] status;
   modport regs(output act, cond, ovl_level, ovl_timer, rel_cur, rel_freq,
                rel_timer, eng_freq, eng_timer, input status);
   modport core(input act, cond, ovl_level, ovl_timer, rel_cur, rel_freq,
                rel_timer, eng_freq, eng_timer, output status);
endinterface // ovb_cfg_if

// ===== hdl/ovb_hold_timer.sv
`timescale 1ns/1ps
module ovb_hold_timer
   import ovb_pkg::*;
#(
   parameter int W = 16,
   parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic cond_in,
   input wire logic [W-1:0] limit_in,
   output logic done_out
);
   localparam int CW = $clog2(TICK_CYCLES + 1);
   logic [CW-1:0] cyc_q;
   logic [W-1:0] cnt_q;
   // own prescaler restarts with the condition, so the hold is exact
   wire tick_w = (cyc_q == CW'(TICK_CYCLES - 1));
   wire run_w = cond_in && (cnt_q < limit_in);

   always_ff @(posedge clk_in) begin
      if (rst_in || !cond_in) begin
         cyc_q <= '0;
         cnt_q <= '0;
      end else if (run_w) begin
         cyc_q <= tick_w ? '0 : cyc_q + 1'b1;
         cnt_q <= tick_w ? cnt_q + 1'b1 : cnt_q;
      end
   end

   assign done_out = cond_in && (cnt_q >= limit_in);
endmodule // ovb_hold_timer

// ===== hdl/ovb_avs_regs.sv
`timescale 1ns/1ps
module ovb_avs_regs
   import ovb_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [3:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [31:0] writedata_in,
   output logic [31:0] readdata_out,
   output logic waitrequest_out,
   ovb_cfg_if.regs cfg
);
   // out of range release and engage settings saturate; overload settings keep only the low 16 bits
   function automatic logic [SET_W-1:0] clamp(input logic [31:0] v,
                                              input logic [SET_W-1:0] mx);
      clamp = (v > {24'h000000, mx}) ? mx : v[SET_W-1:0];
   endfunction

   wire req_w = read_in || write_in;
   wire wr_w = write_in && !waitrequest_out;
   wire [31:0] rd_w =
      (address_in == REG_CTRL) ? {28'h0000000, cfg.cond, cfg.act} :
      (address_in == REG_OVL_LEVEL) ? {16'h0000, cfg.ovl_level} :
      (address_in == REG_OVL_TIMER) ? {16'h0000, cfg.ovl_timer} :
      (address_in == REG_REL_CUR) ? {24'h000000, cfg.rel_cur} :
      (address_in == REG_REL_FREQ) ? {24'h000000, cfg.rel_freq} :
      (address_in == REG_REL_TIMER) ? {24'h000000, cfg.rel_timer} :
      (address_in == REG_ENG_FREQ) ? {24'h000000, cfg.eng_freq} :
      (address_in == REG_ENG_TIMER) ? {24'h000000, cfg.eng_timer} :
      (address_in == REG_STATUS) ? {27'h0000000, cfg.status} : 32'h00000000;

   // one wait cycle per access, read data sampled on its first cycle
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         waitrequest_out <= 1'b1;
         readdata_out <= 32'h00000000;
      end else begin
         waitrequest_out <= !(req_w && waitrequest_out);
         if (read_in && waitrequest_out) readdata_out <= rd_w;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cfg.act <= RST_ACT;
         cfg.cond <= RST_COND;
         cfg.ovl_level <= RST_OVL_LEVEL;
         cfg.ovl_timer <= RST_OVL_TIMER;
         cfg.rel_cur <= RST_SET;
         cfg.rel_freq <= RST_SET;
         cfg.rel_timer <= RST_SET;
         cfg.eng_freq <= RST_SET;
         cfg.eng_timer <= RST_SET;
      end else if (wr_w) begin
         if (address_in == REG_CTRL) begin
            cfg.act <= writedata_in[CTRL_ACT_LSB +: 2];
            cfg.cond <= writedata_in[CTRL_COND_LSB +: 2];
         end else if (address_in == REG_OVL_LEVEL) begin
            cfg.ovl_level <= writedata_in[MEAS_W-1:0];
         end else if (address_in == REG_OVL_TIMER) begin
            cfg.ovl_timer <= writedata_in[MEAS_W-1:0];
         end else if (address_in == REG_REL_CUR) begin
            cfg.rel_cur <= clamp(writedata_in, REL_CUR_MAX);
         end else if (address_in == REG_REL_FREQ) begin
            cfg.rel_freq <= clamp(writedata_in, FREQ_MAX);
         end else if (address_in == REG_REL_TIMER) begin
            cfg.rel_timer <= clamp(writedata_in, HOLD_MAX);
         end else if (address_in == REG_ENG_FREQ) begin
            cfg.eng_freq <= clamp(writedata_in, FREQ_MAX);
         end else if (address_in == REG_ENG_TIMER) begin
            cfg.eng_timer <= clamp(writedata_in, HOLD_MAX);
         end
      end
   end

   property p_clamp;
      @(posedge clk_in) disable iff (rst_in)
      cfg.rel_cur <= REL_CUR_MAX && cfg.rel_freq <= FREQ_MAX &&
      cfg.eng_freq <= FREQ_MAX && cfg.rel_timer <= HOLD_MAX &&
      cfg.eng_timer <= HOLD_MAX;
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("setting above its range");
endmodule // ovb_avs_regs

// ===== hdl/ovb_top.sv
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ovb_top
   import ovb_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DFLT,
   parameter int MW = MEAS_W
) (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic [3:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   input wire logic RUN_IN,
   input wire logic ALARM_IN,
   input wire logic COAST_STOP_CMD_IN,
   input wire logic MOTOR2_SEL_IN,
   input wire logic [1:0] OP_STATE_IN,
   input wire logic [MW-1:0] LOAD_INDEX_IN,
   input wire logic [MW-1:0] OUT_CURRENT_IN,
   input wire logic [MW-1:0] OUT_FREQ_IN,
   output logic STOP_DECEL_OUT,
   output logic STOP_COAST_OUT,
   output logic TORQUE_HOLD_OUT,
   output logic OVL_TRIPPED_OUT,
   output logic BRAKE_RELEASE_OUT
);
   ovb_cfg_if cfg();

   ovb_avs_regs u_regs (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .address_in(AVS_ADDRESS_IN),
      .read_in(AVS_READ_IN),
      .write_in(AVS_WRITE_IN),
      .writedata_in(AVS_WRITEDATA_IN),
      .readdata_out(AVS_READDATA_OUT),
      .waitrequest_out(AVS_WAITREQUEST_OUT),
      .cfg(cfg.regs)
   );

   // terminal inputs come from pins: two stages before any use
   localparam int NPIN = 4;
   logic [NPIN-1:0] pin_w;
   logic [NPIN-1:0] meta_q;
   logic [NPIN-1:0] sync_q;
   assign pin_w = {MOTOR2_SEL_IN, COAST_STOP_CMD_IN, ALARM_IN, RUN_IN};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge CLK_IN) begin
            if (RST_IN) begin
               meta_q[gi] <= 1'b0;
               sync_q[gi] <= 1'b0;
            end else begin
               meta_q[gi] <= pin_w[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

   wire run_s = sync_q[0];
   wire alarm_s = sync_q[1];
   wire coast_s = sync_q[2];
   wire motor2_s = sync_q[3];

   // ---- overload stop ----
   // measured values come from drive logic on this clock, used directly
   ovb_act_e act_w;
   ovb_cond_e cond_w;
   ovb_op_e op_w;
   ovb_act_e latched_act_q;
   ovb_act_e latched_act_d;
   logic latched_q;
   logic latched_d;
   logic ovl_done_w;

   assign act_w = ovb_act_e'(cfg.act);
   assign cond_w = ovb_cond_e'(cfg.cond);
   assign op_w = ovb_op_e'(OP_STATE_IN);

   wire state_ok_w =
      (cond_w == COND_ALL) ||
      (cond_w == COND_CONST && op_w == OP_CONST) ||
      (cond_w == COND_CONST_DECEL &&
       (op_w == OP_CONST || op_w == OP_DECEL));
   wire over_w = LOAD_INDEX_IN > cfg.ovl_level;
   wire armed_w = (act_w != ACT_OFF) && run_s && state_ok_w &&
                  over_w && !latched_q;
   wire timed_act_w = (act_w == ACT_DECEL) || (act_w == ACT_COAST);

   ovb_hold_timer #(
      .W(MEAS_W),
      .TICK_CYCLES(TICK_CYCLES)
   ) u_ovl_tmr (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .cond_in(armed_w),
      .limit_in(cfg.ovl_timer),
      .done_out(ovl_done_w)
   );

   // mode 3 must brake on the torque limit at once, a delay defeats it
   wire trig_w = armed_w &&
      ((act_w == ACT_HOLD) ||
       (timed_act_w && ovl_done_w));

   // trip needs run, clear needs run off: the two never meet
   assign latched_d = !run_s ? 1'b0 :
                      trig_w ? 1'b1 : latched_q;
   assign latched_act_d = trig_w ? act_w : latched_act_q;

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         latched_q <= 1'b0;
         latched_act_q <= ACT_OFF;
      end else begin
         latched_q <= latched_d;
         latched_act_q <= latched_act_d;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         STOP_DECEL_OUT <= 1'b0;
         STOP_COAST_OUT <= 1'b0;
         TORQUE_HOLD_OUT <= 1'b0;
         OVL_TRIPPED_OUT <= 1'b0;
      end else begin
         STOP_DECEL_OUT <= latched_d && latched_act_d == ACT_DECEL;
         STOP_COAST_OUT <= latched_d && latched_act_d == ACT_COAST;
         TORQUE_HOLD_OUT <= latched_d && latched_act_d == ACT_HOLD;
         OVL_TRIPPED_OUT <= latched_d;
      end
   end

   // ---- brake sequencing ----
   ovb_brk_e brk_q;
   ovb_brk_e brk_d;
   logic rel_done_w;
   logic eng_done_w;

   wire rel_cond_w = (OUT_CURRENT_IN > {8'h00, cfg.rel_cur}) &&
                     (OUT_FREQ_IN > {8'h00, cfg.rel_freq});
   wire eng_cond_w = !run_s &&
                     (OUT_FREQ_IN < {8'h00, cfg.eng_freq});
   // output cut by alarm, coast command or a coasting overload trip
   wire shutdown_w = alarm_s || coast_s || STOP_COAST_OUT;

   ovb_hold_timer #(
      .W(SET_W),
      .TICK_CYCLES(TICK_CYCLES)
   ) u_rel_tmr (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .cond_in(rel_cond_w),
      .limit_in(cfg.rel_timer),
      .done_out(rel_done_w)
   );

   ovb_hold_timer #(
      .W(SET_W),
      .TICK_CYCLES(TICK_CYCLES)
   ) u_eng_tmr (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .cond_in(eng_cond_w),
      .limit_in(cfg.eng_timer),
      .done_out(eng_done_w)
   );

   always_comb begin
      brk_d = brk_q;
      if (shutdown_w || motor2_s) begin
         brk_d = BRK_ENGAGED;
      end else begin
         case (brk_q)
            BRK_ENGAGED: begin
               if (rel_done_w) brk_d = BRK_RELEASED;
            end
            BRK_RELEASED: begin
               if (eng_done_w) brk_d = BRK_ENGAGED;
            end
            default: brk_d = BRK_ENGAGED;
         endcase
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         brk_q <= BRK_ENGAGED;
         BRAKE_RELEASE_OUT <= 1'b0;
      end else begin
         brk_q <= brk_d;
         BRAKE_RELEASE_OUT <= (brk_d == BRK_RELEASED);
      end
   end

   assign cfg.status = {TORQUE_HOLD_OUT, STOP_COAST_OUT, STOP_DECEL_OUT,
                        OVL_TRIPPED_OUT, BRAKE_RELEASE_OUT};

   // ---- checks ----
   property p_ovl_gate;
      @(posedge CLK_IN) disable iff (RST_IN)
      (cond_w == COND_CONST && op_w != OP_CONST) ||
      (cond_w == COND_CONST_DECEL && op_w == OP_ACCEL)
      |=> !$rose(OVL_TRIPPED_OUT);
   endproperty
   a_ovl_gate: assert property (p_ovl_gate)
      else $error("overload tripped outside its operating state");

   property p_ovl_off;
      @(posedge CLK_IN) disable iff (RST_IN)
      act_w == ACT_OFF && !latched_q |=> !OVL_TRIPPED_OUT;
   endproperty
   a_ovl_off: assert property (p_ovl_off)
      else $error("overload tripped while disabled");

   property p_ovl_timed;
      @(posedge CLK_IN) disable iff (RST_IN)
      $rose(latched_q) && latched_act_q != ACT_HOLD |-> $past(ovl_done_w);
   endproperty
   a_ovl_timed: assert property (p_ovl_timed)
      else $error("timed overload trip before timer expiry");

   property p_ovl_hold;
      @(posedge CLK_IN) disable iff (RST_IN)
      armed_w && act_w == ACT_HOLD |=> TORQUE_HOLD_OUT && OVL_TRIPPED_OUT;
   endproperty
   a_ovl_hold: assert property (p_ovl_hold)
      else $error("hold mode did not act at once");

   property p_ovl_latch;
      @(posedge CLK_IN) disable iff (RST_IN)
      OVL_TRIPPED_OUT && run_s |=> OVL_TRIPPED_OUT;
   endproperty
   a_ovl_latch: assert property (p_ovl_latch)
      else $error("overload trip released while running");

   property p_brk_rise;
      @(posedge CLK_IN) disable iff (RST_IN)
      $rose(BRAKE_RELEASE_OUT) |-> $past(rel_done_w) && $past(rel_cond_w);
   endproperty
   a_brk_rise: assert property (p_brk_rise)
      else $error("brake released without qualified current and freq");

   property p_brk_fall;
      @(posedge CLK_IN) disable iff (RST_IN)
      $fell(BRAKE_RELEASE_OUT) |->
         $past(eng_done_w) || $past(shutdown_w) || $past(motor2_s);
   endproperty
   a_brk_fall: assert property (p_brk_fall)
      else $error("brake engaged without a cause");

   property p_brk_m2;
      @(posedge CLK_IN) disable iff (RST_IN)
      motor2_s |=> !BRAKE_RELEASE_OUT;
   endproperty
   a_brk_m2: assert property (p_brk_m2)
      else $error("brake released with motor 2 selected");

   property p_brk_shut;
      @(posedge CLK_IN) disable iff (RST_IN)
      alarm_s || coast_s |=> !BRAKE_RELEASE_OUT;
   endproperty
   a_brk_shut: assert property (p_brk_shut)
      else $error("brake not engaged at once on shutdown");

   property p_rst;
      @(posedge CLK_IN)
      RST_IN |=> !BRAKE_RELEASE_OUT && !OVL_TRIPPED_OUT && !STOP_DECEL_OUT;
   endproperty
   a_rst: assert property (p_rst)
      else $error("outputs not cleared by reset");
endmodule // ovb_top

// ===== verification/ovb_drive_model.sv
`timescale 1ns/1ps
module ovb_drive_model
   import ovb_pkg::*;
#(
   parameter int MW = MEAS_W
) (
   input wire logic clk_in,
   input wire logic [3:0] pin_cmd_in,
   input wire logic [1:0] op_cmd_in,
   input wire logic [MW-1:0] load_cmd_in,
   input wire logic [MW-1:0] cur_cmd_in,
   input wire logic [MW-1:0] freq_cmd_in,
   input wire logic coast_in,
   output logic [3:0] pin_out,
   output logic [1:0] op_out,
   output logic [MW-1:0] load_out,
   output logic [MW-1:0] cur_out,
   output logic [MW-1:0] freq_out
);
   initial begin
      pin_out = 4'h0;
      op_out = 2'h0;
      load_out = {MW{1'b0}};
      cur_out = {MW{1'b0}};
      freq_out = {MW{1'b0}};
   end
   // a cut output drops current and speed at once; harsher than a real
   // coasting shaft, so brake logic sees the worst case
   always @(posedge clk_in) begin
      pin_out <= pin_cmd_in;
      op_out <= op_cmd_in;
      load_out <= load_cmd_in;
      cur_out <= coast_in ? {MW{1'b0}} : cur_cmd_in;
      freq_out <= coast_in ? {MW{1'b0}} : freq_cmd_in;
   end
endmodule // ovb_drive_model

// ===== verification/ovb_top_bench.sv
`timescale 1ns/1ps
module ovb_top_bench
   import ovb_pkg::*;
;
   localparam int TK = 4;
   localparam logic [4:0] BRK = 5'h10;
   localparam logic [4:0] TRP = 5'h08;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] av_addr = 4'h0;
   logic av_rd = 1'b0;
   logic av_wr = 1'b0;
   logic [31:0] av_wd = 32'h0;
   logic [31:0] av_rdata;
   logic av_wait;
   logic [3:0] pins = 4'h0;
   logic [1:0] op = 2'h0;
   logic [15:0] load = 16'h0;
   logic [15:0] cur = 16'h0;
   logic [15:0] freq = 16'h0;
   logic [3:0] m_pins;
   logic [1:0] m_op;
   logic [15:0] m_load, m_cur, m_freq;
   logic decel, coast, hold, trip, brake;
   wire [4:0] outs = {brake, trip, hold, coast, decel};
   int error_cnt = 0;
   int total_checks = 0;

   always #2.5 clk = ~clk;

   ovb_drive_model #(.MW(16)) ovb_drive_model_inst (.clk_in(clk),
      .pin_cmd_in(pins), .op_cmd_in(op), .load_cmd_in(load),
      .cur_cmd_in(cur), .freq_cmd_in(freq), .coast_in(coast),
      .pin_out(m_pins), .op_out(m_op), .load_out(m_load),
      .cur_out(m_cur), .freq_out(m_freq));

   ovb_top #(.TICK_CYCLES(TK), .MW(16)) ovb_top_inst (.CLK_IN(clk),
      .RST_IN(rst), .AVS_ADDRESS_IN(av_addr), .AVS_READ_IN(av_rd),
      .AVS_WRITE_IN(av_wr), .AVS_WRITEDATA_IN(av_wd),
      .AVS_READDATA_OUT(av_rdata), .AVS_WAITREQUEST_OUT(av_wait),
      .RUN_IN(m_pins[0]), .ALARM_IN(m_pins[1]),
      .COAST_STOP_CMD_IN(m_pins[2]), .MOTOR2_SEL_IN(m_pins[3]),
      .OP_STATE_IN(m_op), .LOAD_INDEX_IN(m_load),
      .OUT_CURRENT_IN(m_cur), .OUT_FREQ_IN(m_freq),
      .STOP_DECEL_OUT(decel), .STOP_COAST_OUT(coast),
      .TORQUE_HOLD_OUT(hold), .OVL_TRIPPED_OUT(trip),
      .BRAKE_RELEASE_OUT(brake));

   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check_word(input logic [31:0] got, exp, input string m);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic check_cnt(input int n, lo, hi, input string m);
      total_checks++;
      if (n < lo || n > hi) begin
         error_cnt++;
         $display("[FAIL] %0t %s took %0d cycles", $time, m, n);
      end
   endtask

   task automatic wait_outs(input logic [4:0] mk, ex, input int bnd,
                            output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while ((outs & mk) !== ex && n < bnd);
      if ((outs & mk) !== ex) begin
         error_cnt++;
         $display("[FAIL] %0t output wait timed out", $time);
         finish_test();
      end
   endtask

   task automatic hold_outs(input logic [4:0] mk, ex, input int cyc);
      repeat (cyc) begin
         @(posedge clk);
         #1;
         check_word(32'(outs & mk), 32'(ex), "output level");
      end
   endtask

   // software side also touches codes beyond the engage timer: status and code 9
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      int i;
      @(posedge clk);
      av_addr <= a;
      av_wd <= wd;
      av_wr <= wr;
      av_rd <= ~wr;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (av_wait !== 1'b0 && i < 50);
      rd = av_rdata;
      av_wr <= 1'b0;
      av_rd <= 1'b0;
      if (i >= 50) begin
         error_cnt++;
         $display("[FAIL] %0t bus wait timed out", $time);
         finish_test();
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      check_word(r, e, "register read");
   endtask

   task automatic release_brk();
      int n;
      @(posedge clk);
      pins <= 4'h1;
      cur <= 16'h003C;
      freq <= 16'h003C;
      wait_outs(BRK, BRK, 60, n);
   endtask

   task automatic t_reset();
      for (int i = 0; i < 10; i++) begin
         rd_chk(4'(i), (i == 1) ? 32'h00000064 : 32'h0);
      end
      check_word(32'(outs), 32'h0, "outputs after reset");
   endtask

   task automatic t_regs();
      logic [3:0] ad [7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h2, 4'h9};
      logic [15:0] wd [7] = '{16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF,
                              16'h00FF, 16'h1234, 16'h005A};
      logic [15:0] ex [7] = '{16'h00C8, 16'h00FA, 16'h0032, 16'h00FA,
                              16'h0032, 16'h1234, 16'h0000};
      for (int i = 0; i < 7; i++) begin
         wr_reg(ad[i], 32'(wd[i]));
         rd_chk(ad[i], 32'(ex[i]));
      end
      wr_reg(REG_REL_CUR, 32'h32);
      wr_reg(REG_REL_FREQ, 32'h32);
      wr_reg(REG_REL_TIMER, 32'h2);
      wr_reg(REG_ENG_FREQ, 32'h1E);
      wr_reg(REG_ENG_TIMER, 32'h1);
   endtask

   task automatic t_brake();
      int n;
      @(posedge clk);
      pins <= 4'h1;
      cur <= 16'h003C;
      freq <= 16'h0032;
      hold_outs(BRK, 5'h0, 30);
      freq <= 16'h003C;
      wait_outs(BRK, BRK, 40, n);
      check_cnt(n, 2 * TK + 1, 2 * TK + 3, "release delay");
      @(posedge clk);
      freq <= 16'h0014;
      cur <= 16'h0000;
      hold_outs(BRK, BRK, 30);
      pins <= 4'h0;
      wait_outs(BRK, 5'h0, 30, n);
      check_cnt(n, TK + 3, TK + 5, "engage delay");
      for (int k = 1; k < 4; k++) begin
         release_brk();
         @(posedge clk);
         pins <= 4'h1 | (4'h1 << k);
         wait_outs(BRK, 5'h0, 6, n);
         hold_outs(BRK, 5'h0, 20);
         pins <= 4'h1;
      end
      @(posedge clk);
      pins <= 4'h0;
      cur <= 16'h0000;
      freq <= 16'h0000;
   endtask

   task automatic t_modes();
      int n;
      logic [4:0] mk;
      wr_reg(REG_OVL_TIMER, 32'h3);
      for (int m = 0; m < 4; m++) begin
         wr_reg(REG_CTRL, 32'(m | 8));
         @(posedge clk);
         op <= 2'h1;
         load <= 16'h0096;
         pins <= 4'h1;
         if (m == 0) begin
            hold_outs(5'h0F, 5'h0, 40);
         end else begin
            mk = TRP | 5'(1 << (m - 1));
            wait_outs(mk, mk, 40, n);
            if (m == 3) begin
               check_cnt(n, 1, 6, "hold mode delay");
            end else begin
               check_cnt(n, 3 * TK + 3, 3 * TK + 5, "trip delay");
            end
            load <= 16'h0032;
            hold_outs(mk, mk, 20);
            rd_chk(REG_STATUS, 32'(2 | (1 << (m + 1))));
         end
         @(posedge clk);
         pins <= 4'h0;
         wait_outs(TRP, 5'h0, 10, n);
         hold_outs(TRP, 5'h0, 4);
      end
   endtask

   task automatic t_cond();
      int n;
      logic ok;
      for (int c = 0; c < 3; c++) begin
         wr_reg(REG_CTRL, 32'(3 | (c << 2)));
         for (int o = 0; o < 3; o++) begin
            ok = (c == 2) || (o == 1) || (c == 0 && o == 2);
            @(posedge clk);
            op <= 2'(o);
            pins <= 4'h1;
            load <= 16'h0096;
            if (ok) begin
               wait_outs(TRP, TRP, 10, n);
            end else begin
               hold_outs(TRP, 5'h0, 12);
            end
            @(posedge clk);
            pins <= 4'h0;
            wait_outs(TRP, 5'h0, 10, n);
         end
      end
   endtask

   // run stays on, so only reset can engage the brake here; current and
   // speed drop so the zeroed settings do not release it again at once
   task automatic t_midreset();
      release_brk();
      @(posedge clk);
      rst <= 1'b1;
      cur <= 16'h0000;
      freq <= 16'h0000;
      repeat (3) @(posedge clk);
      #1;
      check_word(32'(outs), 32'h0, "outputs in second reset");
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check_word(32'(outs), 32'h0, "outputs after second reset");
      hold_outs(5'h1F, 5'h0, 2);
      rd_chk(REG_OVL_LEVEL, 32'(RST_OVL_LEVEL));
      rd_chk(REG_REL_CUR, 32'(RST_SET));
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_brake();
      t_modes();
      t_cond();
      t_midreset();
      finish_test();
   end

   initial begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
endmodule // ovb_top_bench
